// >>> ofs_pkg.sv
// Shared constants of the offline switcher fault sequencer.
// Assumes a single 125 MHz core clock and an APB register port with 32-bit data.
package ofs_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_KHZ        = 125000;
  localparam int VALID_TIME_MS  = 53;
  localparam int OFF_TIME_MS    = 420;
  localparam int SS_TIME_MS     = 1;
  localparam int JIT_SWEEP_HZ   = 300;
  localparam int VALID_CYC      = CLK_KHZ * VALID_TIME_MS;
  localparam int OFF_CYC        = CLK_KHZ * OFF_TIME_MS;
  localparam int SS_STEP_CYC    = (CLK_KHZ * SS_TIME_MS) / 256;
  localparam int JIT_STEP_CYC   = (CLK_KHZ * 1000) / (JIT_SWEEP_HZ * 256);
  localparam int CNT_W          = 26;
  localparam int STEP_W         = 12;

  // ****************************************************************
  // Feedback levels (uA magnitude) and frequencies
  // ****************************************************************
  localparam logic [7:0]  FB_FAULT_UA     = 8'h23;
  localparam logic [7:0]  FB_FOLD_UA      = 8'h44;
  localparam logic [7:0]  FB_FOLD_END_UA  = 8'h64;
  localparam logic [7:0]  FB_SKIP_UA      = 8'h78;
  localparam logic [15:0] NOM_FREQ_KHZ    = 16'h0041;
  localparam logic [15:0] MIN_FREQ_KHZ    = 16'h0019;
  localparam logic [31:0] JIT_PCT         = 32'h0000_0006;
  localparam logic [7:0]  PEAK_MAX        = 8'hff;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_INTSTAT = 8'h08;
  localparam logic [7:0] ADDR_INTMASK = 8'h0c;
  localparam int         INT_W        = 4;
  localparam int         INT_OVLD     = 0;
  localparam int         INT_OVP      = 1;
  localparam int         INT_UNDERVOLTAGE_LOCKOUT     = 2;
  localparam int         INT_TSD      = 3;
  localparam logic       CTRL_RST     = 1'h1;

  typedef enum logic [4:0] {
    ST_LOCKOUT = 5'h01,
    ST_DRAIN   = 5'h02,
    ST_RUN     = 5'h04,
    ST_OFF     = 5'h08,
    ST_HOLD    = 5'h10
  } ofs_state_t;

endpackage : ofs_pkg

// >>> ofs_sequencer.sv
// Mode and protection sequencer of an offline switching regulator with APB registers.
// Assumes comparator and feedback inputs are synchronous to core_clk.
//
// Functional notes
// - Feedback below fault level raises peak-limit flag and starts validation timer.
// - Flag still set at timer expiry stops drive for the full off interval.
// - After off interval retry one validation period; alternate while fault persists.
// - Overload clearing during retry returns to normal regulated switching.
// - Clamp overcurrent stops switching at once, then waits one off interval.
// - Restart after overvoltage resumes if gone, else repeats the burst cycle.
// - After any fault recovery keep switch disabled while drain below enable threshold.
// - Every switching start ramps allowed peak current from low to maximum.
// - Frequency folds back between foldback start and end feedback levels.
// - Demand falling past minimum foldback frequency enters skip-cycle mode.
// - Jitter stays active during frequency foldback.
// - Supply reaching turn-on stops start-up source; drive only with drain enabled. Drain is checked only on leaving ST_DRAIN, not during ST_RUN.
// - Self-supply: source on below recharge level, off at turn-on level.
// - Supply at turn-off level ceases operation.
// - No start-up charging while the power switch conducts; the registered source flag can overlap the first conducting cycle.
// - Reduced start-up current below low supply threshold, nominal above.
// - Internal sawtooth jitter at fixed sweep rate, never defeatable.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module ofs_sequencer #(
  parameter int VALID_CYCLES = ofs_pkg::VALID_CYC,
  parameter int OFF_CYCLES   = ofs_pkg::OFF_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  fbCurrent,
  input  wire logic        supplyAboveTurnOn,
  input  wire logic        supplyBelowRecharge,
  input  wire logic        supplyBelowTurnOff,
  input  wire logic        supplyAboveLow,
  input  wire logic        clampOverCurrent,
  input  wire logic        drainAboveEnable,
  input  wire logic        thermalShutdown,
  input  wire logic        switchConducting,
  output logic             gateEnable,
  output logic             startupSrcOn,
  output logic             startupNominal,
  output logic             peakLimitFlag,
  output logic      [7:0]  peakLimit,
  output logic      [15:0] switchFreq,
  output logic             skipActive,
  output logic             burstMode,
  output logic             irq
);

  // ****************************************************************
  // State and counters
  // ****************************************************************
  ofs_pkg::ofs_state_t           state_ff, nxt_state;
  logic [ofs_pkg::CNT_W-1:0]     valCnt_ff;
  logic [ofs_pkg::CNT_W-1:0]     offCnt_ff;
  logic [ofs_pkg::STEP_W-1:0]    ssCnt_ff;
  logic [ofs_pkg::STEP_W-1:0]    jitCnt_ff;
  logic [7:0]                    saw_ff;
  logic [7:0]                    peak_ff;
  logic                          gate_ff;
  logic                          srcOn_ff;
  logic                          srcNom_ff;
  logic                          flag_ff;
  logic                          burst_ff;
  logic                          skip_ff;
  logic [15:0]                   freq_ff;
  logic                          recharge_ff;
  logic                          swEnable_ff;
  logic [ofs_pkg::INT_W-1:0]     intStat_ff;
  logic [ofs_pkg::INT_W-1:0]     intMask_ff;
  logic [ofs_pkg::INT_W-1:0]     event_s;
  logic                          irq_ff;
  logic [31:0]                   prdata_ff;
  logic                          pready_ff;
  logic                          pslverr_ff;
  logic                          fbFault;
  logic                          valDone;
  logic                          offDone;
  logic                          wrAccess;
  logic                          mapped;
  logic [15:0]                   foldKhz;
  logic [31:0]                   base10;
  logic [31:0]                   dev;

  assign fbFault = fbCurrent < ofs_pkg::FB_FAULT_UA;
  assign valDone = valCnt_ff == ofs_pkg::CNT_W'(VALID_CYCLES - 1);
  assign offDone = offCnt_ff == ofs_pkg::CNT_W'(OFF_CYCLES - 1);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ofs_pkg::ST_LOCKOUT: begin
        if (supplyAboveTurnOn) begin
          nxt_state = ofs_pkg::ST_DRAIN;
        end
      end
      ofs_pkg::ST_DRAIN: begin
        if (drainAboveEnable && swEnable_ff) begin
          nxt_state = ofs_pkg::ST_RUN;
        end
      end
      ofs_pkg::ST_RUN: begin
        if (clampOverCurrent) begin
          nxt_state = ofs_pkg::ST_OFF;
        end else if (valDone && flag_ff && fbFault) begin
          nxt_state = ofs_pkg::ST_OFF;
        end else if (!swEnable_ff) begin
          nxt_state = ofs_pkg::ST_DRAIN;
        end
      end
      ofs_pkg::ST_OFF: begin
        if (offDone) begin
          nxt_state = ofs_pkg::ST_DRAIN;
        end
      end
      ofs_pkg::ST_HOLD: begin
        if (!thermalShutdown) begin
          nxt_state = ofs_pkg::ST_DRAIN;
        end
      end
      default: begin
        nxt_state = ofs_pkg::ST_LOCKOUT;
      end
    endcase
    // Lockout overrides every state; thermal overrides every state except lockout
    if (supplyBelowTurnOff) begin
      nxt_state = ofs_pkg::ST_LOCKOUT;
    end else if (thermalShutdown && state_ff != ofs_pkg::ST_LOCKOUT) begin
      nxt_state = ofs_pkg::ST_HOLD;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= ofs_pkg::ST_LOCKOUT;
    end else if (clkEn) begin
      state_ff <= nxt_state;
    end
  end

  // Gate follows the next state so a trip removes drive on the very next edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gate_ff <= 1'b0;
    end else if (clkEn) begin
      gate_ff <= nxt_state == ofs_pkg::ST_RUN;
    end
  end

  // ****************************************************************
  // Overload validation and off interval
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flag_ff   <= 1'b0;
      valCnt_ff <= '0;
    end else if (clkEn) begin
      if (state_ff != ofs_pkg::ST_RUN || nxt_state != ofs_pkg::ST_RUN || !fbFault) begin
        flag_ff   <= 1'b0;
        valCnt_ff <= '0;
      end else begin
        flag_ff   <= 1'b1;
        valCnt_ff <= valCnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      offCnt_ff <= '0;
    end else if (clkEn) begin
      if (state_ff == ofs_pkg::ST_OFF && nxt_state == ofs_pkg::ST_OFF) begin
        offCnt_ff <= offCnt_ff + 1'b1;
      end else begin
        offCnt_ff <= '0;
      end
    end
  end

  // Burst stays flagged across retries until a retry runs clean
  always_ff @(posedge core_clk) begin
    if (rst) begin
      burst_ff <= 1'b0;
    end else if (clkEn) begin
      if (nxt_state == ofs_pkg::ST_OFF) begin
        burst_ff <= 1'b1;
      end else if (nxt_state == ofs_pkg::ST_LOCKOUT) begin
        burst_ff <= 1'b0;
      end else if (state_ff == ofs_pkg::ST_RUN && !fbFault && !clampOverCurrent) begin
        burst_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Soft-start ramp
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      peak_ff  <= '0;
      ssCnt_ff <= '0;
    end else if (clkEn) begin
      if (nxt_state != ofs_pkg::ST_RUN || state_ff != ofs_pkg::ST_RUN) begin
        peak_ff  <= '0;
        ssCnt_ff <= '0;
      end else if (peak_ff != ofs_pkg::PEAK_MAX) begin
        if (ssCnt_ff == ofs_pkg::STEP_W'(ofs_pkg::SS_STEP_CYC - 1)) begin
          ssCnt_ff <= '0;
          peak_ff  <= peak_ff + 1'b1;
        end else begin
          ssCnt_ff <= ssCnt_ff + 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Start-up current source
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      recharge_ff <= 1'b1;
    end else if (clkEn) begin
      if (supplyAboveTurnOn) begin
        recharge_ff <= 1'b0;
      end else if (supplyBelowRecharge || state_ff == ofs_pkg::ST_LOCKOUT) begin
        recharge_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      srcOn_ff  <= 1'b0;
      srcNom_ff <= 1'b0;
    end else if (clkEn) begin
      srcOn_ff  <= recharge_ff && !supplyAboveTurnOn && !switchConducting;
      srcNom_ff <= supplyAboveLow;
    end
  end

  // ****************************************************************
  // Foldback, skip and jitter
  // ****************************************************************
  always_comb begin
    if (fbCurrent <= ofs_pkg::FB_FOLD_UA) begin
      foldKhz = ofs_pkg::NOM_FREQ_KHZ;
    end else if (fbCurrent >= ofs_pkg::FB_FOLD_END_UA) begin
      foldKhz = ofs_pkg::MIN_FREQ_KHZ;
    end else begin
      foldKhz = ofs_pkg::NOM_FREQ_KHZ - 16'(
        (16'(fbCurrent - ofs_pkg::FB_FOLD_UA) * (ofs_pkg::NOM_FREQ_KHZ - ofs_pkg::MIN_FREQ_KHZ))
        / 16'(ofs_pkg::FB_FOLD_END_UA - ofs_pkg::FB_FOLD_UA));
    end
  end

  // Output in 100 Hz units; jitter applied after foldback so it never drops out
  assign base10 = 32'(foldKhz) * 32'h0000_000a;
  assign dev    = (base10 * (ofs_pkg::JIT_PCT * 32'h0000_0002) * 32'(saw_ff)) / 32'h0000_6400;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      jitCnt_ff <= '0;
      saw_ff    <= '0;
    end else if (clkEn) begin
      if (jitCnt_ff == ofs_pkg::STEP_W'(ofs_pkg::JIT_STEP_CYC - 1)) begin
        jitCnt_ff <= '0;
        saw_ff    <= saw_ff + 1'b1;
      end else begin
        jitCnt_ff <= jitCnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      freq_ff <= 16'h0000;
      skip_ff <= 1'b0;
    end else if (clkEn) begin
      freq_ff <= 16'(base10 - (base10 * ofs_pkg::JIT_PCT) / 32'h0000_0064 + dev);
      skip_ff <= fbCurrent >= ofs_pkg::FB_SKIP_UA && foldKhz == ofs_pkg::MIN_FREQ_KHZ;
    end
  end

  // ****************************************************************
  // APB registers and interrupt
  // ****************************************************************
  // Zero wait state: pready rises in the first access cycle
  assign wrAccess = psel && penable && pwrite && pready_ff;
  assign mapped   = paddr == ofs_pkg::ADDR_CTRL || paddr == ofs_pkg::ADDR_STATUS
                 || paddr == ofs_pkg::ADDR_INTSTAT || paddr == ofs_pkg::ADDR_INTMASK;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else if (clkEn) begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && !mapped;
      prdata_ff  <= '0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          ofs_pkg::ADDR_CTRL:    prdata_ff <= {31'h0, swEnable_ff};
          ofs_pkg::ADDR_STATUS:  prdata_ff <= {16'h0, peak_ff, 1'b0, state_ff,
                                              burst_ff, flag_ff};
          ofs_pkg::ADDR_INTSTAT: prdata_ff <= {28'h0, intStat_ff};
          ofs_pkg::ADDR_INTMASK: prdata_ff <= {28'h0, intMask_ff};
          default:               prdata_ff <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      swEnable_ff <= ofs_pkg::CTRL_RST;
      intMask_ff  <= '0;
    end else if (clkEn && wrAccess) begin
      if (paddr == ofs_pkg::ADDR_CTRL) begin
        swEnable_ff <= pwdata[0];
      end
      if (paddr == ofs_pkg::ADDR_INTMASK) begin
        intMask_ff <= pwdata[ofs_pkg::INT_W-1:0];
      end
    end
  end

  assign event_s[ofs_pkg::INT_OVLD] = state_ff == ofs_pkg::ST_RUN && valDone && flag_ff && fbFault;
  assign event_s[ofs_pkg::INT_OVP]  = state_ff == ofs_pkg::ST_RUN && clampOverCurrent;
  assign event_s[ofs_pkg::INT_UNDERVOLTAGE_LOCKOUT] = supplyBelowTurnOff && state_ff != ofs_pkg::ST_LOCKOUT;
  assign event_s[ofs_pkg::INT_TSD]  = thermalShutdown && state_ff != ofs_pkg::ST_HOLD;

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      intStat_ff <= '0;
    end else if (clkEn) begin
      if (wrAccess && paddr == ofs_pkg::ADDR_INTSTAT) begin
        intStat_ff <= (intStat_ff & ~pwdata[ofs_pkg::INT_W-1:0]) | event_s;
      end else begin
        intStat_ff <= intStat_ff | event_s;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else if (clkEn) begin
      irq_ff <= |(intStat_ff & intMask_ff);
    end
  end

  assign prdata         = prdata_ff;
  assign pready         = pready_ff;
  assign pslverr        = pslverr_ff;
  assign gateEnable     = gate_ff;
  assign startupSrcOn   = srcOn_ff;
  assign startupNominal = srcNom_ff;
  assign peakLimitFlag  = flag_ff;
  assign peakLimit      = peak_ff;
  assign switchFreq     = freq_ff;
  assign skipActive     = skip_ff;
  assign burstMode      = burst_ff;
  assign irq            = irq_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_ovp_stop_drive: assert property (@(posedge core_clk) disable iff (rst)
    (clkEn && state_ff == ofs_pkg::ST_RUN && clampOverCurrent && !supplyBelowTurnOff
      && !thermalShutdown) |=> (!gateEnable && state_ff == ofs_pkg::ST_OFF))
    else $error("drive not stopped on clamp overcurrent");

  a_fault_expiry_off: assert property (@(posedge core_clk) disable iff (rst)
    (clkEn && state_ff == ofs_pkg::ST_RUN && valDone && flag_ff && fbFault
      && !supplyBelowTurnOff && !thermalShutdown) |=> (state_ff == ofs_pkg::ST_OFF))
    else $error("validated overload did not enter off interval");

  a_off_hold_low: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == ofs_pkg::ST_OFF) |-> !gateEnable)
    else $error("switch driven during off interval");

  a_flag_raise: assert property (@(posedge core_clk) disable iff (rst)
    (clkEn && state_ff == ofs_pkg::ST_RUN && nxt_state == ofs_pkg::ST_RUN && fbFault)
      |=> (peakLimitFlag && valCnt_ff == $past(valCnt_ff) + 1'b1))
    else $error("peak-limit flag or timer did not start");

  a_undervoltage_lockout_lockout: assert property (@(posedge core_clk) disable iff (rst)
    (clkEn && supplyBelowTurnOff)
      |=> (state_ff == ofs_pkg::ST_LOCKOUT && !gateEnable && valCnt_ff == '0))
    else $error("undervoltage did not force lockout");

  a_drain_gate: assert property (@(posedge core_clk) disable iff (rst)
    (clkEn && state_ff == ofs_pkg::ST_DRAIN && !drainAboveEnable) |=> !gateEnable)
    else $error("switch enabled with drain below enable threshold");

  a_no_charge_on: assert property (@(posedge core_clk) disable iff (rst)
    (clkEn && switchConducting) |=> !startupSrcOn)
    else $error("start-up source on while switch conducts");

  a_ss_restart: assert property (@(posedge core_clk) disable iff (rst)
    (clkEn && state_ff == ofs_pkg::ST_OFF && nxt_state == ofs_pkg::ST_DRAIN)
      |=> (peakLimit == 8'h00) [*2])
    else $error("soft-start not restarted after off interval");

  a_skip_entry: assert property (@(posedge core_clk) disable iff (rst)
    (clkEn && fbCurrent >= ofs_pkg::FB_SKIP_UA) |=> skipActive)
    else $error("skip mode not entered at low demand");

  a_irq_level: assert property (@(posedge core_clk) disable iff (rst)
    clkEn |=> (irq == |($past(intStat_ff) & $past(intMask_ff))))
    else $error("interrupt does not follow masked status");

endmodule : ofs_sequencer

// >>> ofs_plant.sv
// Behavioural supply capacitor and power switch seen by the sequencer.
// Assumes the bench owns feedback, clamp, drain and thermal stimulus.
`timescale 1ns/1ns
module ofs_plant (
  input  wire logic core_clk,
  input  wire logic startupSrcOn,
  input  wire logic startupNominal,
  input  wire logic gateEnable,
  input  wire logic supplyDrop,
  output logic      supplyAboveTurnOn,
  output logic      supplyBelowRecharge,
  output logic      supplyBelowTurnOff,
  output logic      supplyAboveLow,
  output logic      switchConducting
);
  // ************************************************
  // Supply in tenths of a volt
  // ************************************************
  int supplyDv = 0;
  int tick     = 0;

  // Reduced source charges four times slower; load drains slowly
  always @(posedge core_clk) begin
    tick <= tick + 1;
    if (supplyDrop) begin
      if (supplyDv > 0) supplyDv <= supplyDv - 1;
    end else if (startupSrcOn === 1'b1 && (startupNominal === 1'b1 || tick % 4 == 0)) begin
      if (supplyDv < 90) supplyDv <= supplyDv + 1;
    end else if (tick % 16 == 0 && supplyDv > 0) begin
      supplyDv <= supplyDv - 1;
    end
  end

  assign supplyAboveTurnOn   = supplyDv >= 82;
  assign supplyBelowRecharge = supplyDv < 68;
  assign supplyBelowTurnOff  = supplyDv <= 64;
  assign supplyAboveLow      = supplyDv > 24;
  // Switch conducts half of each eight-cycle period while enabled
  assign switchConducting    = gateEnable === 1'b1 && tick % 8 >= 4;
endmodule : ofs_plant

// >>> offline_switcher_fault_sequencer_tb.sv
// Self-checking bench of the fault sequencer with APB register access.
// Assumes the supply model in ofs_plant and shortened fault timers.
`timescale 1ns/1ns
module offline_switcher_fault_sequencer_tb;
  localparam int VALID = 50;
  localparam int OFF   = 100;
  localparam int G = 0, SRC = 1, RCH = 2, ON = 3, LOW = 4, SKP = 5;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, irq, condPrev;
  logic [7:0]  paddr, fbCurrent, peakLimit;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] switchFreq;
  logic        clampOverCurrent, drainAboveEnable, thermalShutdown, supplyDrop;
  logic        supplyAboveTurnOn, supplyBelowRecharge, supplyBelowTurnOff, supplyAboveLow;
  logic        switchConducting, gateEnable, startupSrcOn, startupNominal;
  logic        peakLimitFlag, skipActive, burstMode, err, clkEn;
  int          num_errors, n_compared, cyc, n, fMin, fMax;
  wire logic [5:0] mon = {skipActive, supplyAboveLow, supplyAboveTurnOn,
                          supplyBelowRecharge, startupSrcOn, gateEnable};

  ofs_sequencer #(.VALID_CYCLES(VALID), .OFF_CYCLES(OFF)) i_dut (
    .core_clk, .rst, .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fbCurrent, .supplyAboveTurnOn, .supplyBelowRecharge,
    .supplyBelowTurnOff, .supplyAboveLow, .clampOverCurrent, .drainAboveEnable,
    .thermalShutdown, .switchConducting, .gateEnable, .startupSrcOn, .startupNominal,
    .peakLimitFlag, .peakLimit, .switchFreq, .skipActive, .burstMode, .irq);
  ofs_plant i_plant (.core_clk, .startupSrcOn, .startupNominal, .gateEnable, .supplyDrop,
    .supplyAboveTurnOn, .supplyBelowRecharge, .supplyBelowTurnOff, .supplyAboveLow,
    .switchConducting);

  // ************************************************
  // Clock, watchdog and shared tasks
  // ************************************************
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // One cycle of overlap is allowed since the source flag is registered
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    condPrev <= switchConducting && clkEn;
    if (startupSrcOn === 1'b1 && switchConducting && condPrev) chk("srcWhileOn", 0, 1);
    if (cyc == 60000) begin
      num_errors++;
      wrap_up();
    end
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdc(input string what, input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
    chk("pslverr", e, err);
  endtask : rdc

  task waitBit(input string what, input int b, input logic lvl, input int lim, output int c);
    c = 0;
    while (mon[b] !== lvl && c < lim) begin
      @(posedge core_clk);
      c++;
    end
    chk(what, lvl, mon[b]);
  endtask : waitBit

  task wrap_up();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  // ************************************************
  // Test sequence
  // ************************************************
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {clampOverCurrent, thermalShutdown, supplyDrop} = '0;
    drainAboveEnable = 1'b1;
    clkEn = 1'b1;
    fbCurrent = 8'h32;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    chk("gateRst", 0, gateEnable);
    rdc("ctrlRst", ofs_pkg::ADDR_CTRL, 32'h1, 1'b0);
    rdc("maskRst", ofs_pkg::ADDR_INTMASK, 32'h0, 1'b0);
    rdc("unmapped", 8'h10, 32'h0, 1'b1);
    apb(1'b1, ofs_pkg::ADDR_INTMASK, 32'hf);
    $display("test registers done");
    waitBit("srcOn", SRC, 1'b1, 20, n);
    chk("reduced", 0, startupNominal);
    waitBit("low", LOW, 1'b1, 500, n);
    repeat (2) @(posedge core_clk);
    chk("nominal", 1, startupNominal);
    waitBit("gateUp", G, 1'b1, 500, n);
    chk("srcOff", 0, startupSrcOn);
    chk("peakStart", 1, peakLimit <= 8'h01);
    repeat (1500) @(posedge core_clk);
    chk("peakRamp", 1, peakLimit >= 8'h02 && peakLimit <= 8'h04);
    waitBit("recharge", RCH, 1'b1, 1000, n);
    waitBit("srcAgain", SRC, 1'b1, 8, n);
    waitBit("turnOn", ON, 1'b1, 200, n);
    repeat (2) @(posedge core_clk);
    chk("srcStop", 0, startupSrcOn);
    $display("test startup done");
    fbCurrent <= 8'h54;
    repeat (4) @(posedge core_clk);
    {fMin, fMax} = {32'hffff, 32'h0};
    repeat (10000) begin
      @(posedge core_clk);
      if (switchFreq < fMin) fMin = switchFreq;
      if (switchFreq > fMax) fMax = switchFreq;
    end
    chk("freqMid", 1, fMin >= 423 && fMax <= 477);
    chk("jitterFold", 1, fMax > fMin);
    fbCurrent <= 8'h64;
    repeat (4) @(posedge core_clk);
    chk("freqEnd", 1, switchFreq >= 16'h00eb && switchFreq <= 16'h0109);
    fbCurrent <= 8'h82;
    waitBit("skipOn", SKP, 1'b1, 20, n);
    fbCurrent <= 8'h32;
    waitBit("skipOff", SKP, 1'b0, 20, n);
    $display("test foldback done");
    fbCurrent <= 8'h14;
    repeat (2) @(posedge core_clk);
    chk("flag", 1, peakLimitFlag);
    // Frozen timer must not advance, so the measured window stays a full period
    clkEn <= 1'b0;
    repeat (20) @(posedge core_clk);
    clkEn <= 1'b1;
    waitBit("validEnd", G, 1'b0, VALID + 5, n);
    chk("validLen", 1, n >= VALID - 4 && n <= VALID + 3);
    chk("burst", 1, burstMode);
    @(posedge core_clk);
    chk("irqOvld", 1, irq);
    waitBit("retry", G, 1'b1, OFF + 10, n);
    chk("offLen", 1, n >= OFF - 2 && n <= OFF + 6);
    chk("peakRetry", 1, peakLimit <= 8'h01);
    waitBit("retryEnd", G, 1'b0, VALID + 10, n);
    chk("retryLen", 1, n >= VALID - 2 && n <= VALID + 4);
    waitBit("retry2", G, 1'b1, OFF + 10, n);
    fbCurrent <= 8'h32;
    repeat (VALID + 20) @(posedge core_clk);
    chk("resume", 1, gateEnable);
    chk("burstOff", 0, burstMode);
    apb(1'b0, ofs_pkg::ADDR_INTSTAT, 32'h0);
    chk("intOvld", 1, rd[ofs_pkg::INT_OVLD]);
    apb(1'b1, ofs_pkg::ADDR_INTSTAT, 32'hf);
    rdc("intClear", ofs_pkg::ADDR_INTSTAT, 32'h0, 1'b0);
    chk("irqClear", 0, irq);
    $display("test overload done");
    apb(1'b1, ofs_pkg::ADDR_INTMASK, 32'h0);
    clampOverCurrent <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("ovpStop", 0, gateEnable);
    clampOverCurrent <= 1'b0;
    repeat (OFF - 10) @(posedge core_clk);
    chk("ovpOff", 0, gateEnable);
    chk("irqMasked", 0, irq);
    drainAboveEnable <= 1'b0;
    repeat (60) @(posedge core_clk);
    chk("drainHold", 0, gateEnable);
    rdc("intOvp", ofs_pkg::ADDR_INTSTAT, 32'h2, 1'b0);
    apb(1'b0, ofs_pkg::ADDR_STATUS, 32'h0);
    chk("stDrain", ofs_pkg::ST_DRAIN, rd[6:2]);
    apb(1'b1, ofs_pkg::ADDR_INTMASK, 32'h2);
    repeat (2) @(posedge core_clk);
    chk("irqUnmask", 1, irq);
    drainAboveEnable <= 1'b1;
    waitBit("ovpResume", G, 1'b1, 10, n);
    apb(1'b1, ofs_pkg::ADDR_INTSTAT, 32'hf);
    repeat (2) @(posedge core_clk);
    chk("irqOff", 0, irq);
    $display("test overvoltage done");
    thermalShutdown <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("tsdStop", 0, gateEnable);
    thermalShutdown <= 1'b0;
    waitBit("tsdResume", G, 1'b1, 20, n);
    supplyDrop <= 1'b1;
    waitBit("uvloStop", G, 1'b0, 100, n);
    chk("uvloLevel", 1, supplyBelowTurnOff);
    supplyDrop <= 1'b0;
    waitBit("uvloRestart", G, 1'b1, 1500, n);
    chk("peakUvlo", 1, peakLimit <= 8'h01);
    $display("test thermal and lockout done");
    wrap_up();
  end
endmodule : offline_switcher_fault_sequencer_tb
